// ===== bench/test_pcs_ctrl_status.sv
/*
  self-checking bench for pcs_ctrl_status: run bit, counting, flags, interrupt.
  assumes pcs_pkg compiled first and pcs_defs.svh on the include path.
*/
`timescale 1ns/1ps
module test_pcs_ctrl_status;
  import pcs_pkg::*;
  localparam int CW = 4;
  logic ref_clk, rst, tick, roll, irq;
  pcs_sfr_req_t req;
  pcs_irq_en_t en;
  logic [4:0] ev, evs;
  logic [7:0] rdata, v, ex;
  logic [CW-1:0] cval;
  int num_errors, total_checks, rolls;
  pcs_ctrl_status #(.CNT_WIDTH(CW)) pcs_ctrl_status_inst (.ref_clk(ref_clk), .rst(rst),
    .sfr_req(req), .sfr_rdata(rdata), .irq_en(en), .count_tick(tick),
    .module_event(ev), .counter_value(cval), .counter_rollover(roll), .array_irq(irq));
  initial
  begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk) {req.wr, req.addr, req.wdata} = {1'b1, a, d};
    @(negedge ref_clk) req.wr = 0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk) {req.rd, req.addr} = {1'b1, a};
    @(negedge ref_clk) d = rdata;
    req.rd = 0;
  endtask
  task automatic ticks(int n);
    repeat (n) @(negedge ref_clk) tick = 1;
    @(negedge ref_clk) tick = 0;
    repeat (3) @(negedge ref_clk);
  endtask
  function automatic logic exp_irq(logic [7:0] r, pcs_irq_en_t e);
    return (r[7] & e.overflow_irq_enable) | (|(r[4:0] & e.module_irq_enable));
  endfunction
  function automatic int exp_count(int start, int n);
    return (start + n) % (1 << CW);
  endfunction
  function automatic int exp_wraps(int start, int n);
    return (start + n) / (1 << CW);
  endfunction
  always @(negedge ref_clk)
    if (roll === 1'b1) rolls++;
  initial
  begin
    #100us;
    num_errors++;
    conclude();
  end
  initial
  begin
    {rst, tick, ev} = {1'b1, 1'b0, 5'h00};
    req = '0;
    en = '0;
    void'($urandom(21));
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk) rst = 0;
    rd(8'hd8, v);
    chk("reset reg", v, 8'h00);
    chk("reset irq", irq, 0);
    $display("test reset done");
    wr(8'hd8, 8'h40);
    ticks(5);
    chk("count run", cval, 5);
    rd(8'hd8, v);
    chk("run bit", v, 8'h40);
    wr(8'hd8, 8'h00);
    ticks(3);
    chk("count held", cval, 5);
    $display("test run done");
    en.overflow_irq_enable = 1;
    wr(8'hd8, 8'h40);
    ticks(11);
    chk("count wrap", cval, exp_count(5, 11));
    rd(8'hd8, v);
    chk("ovf flag", v, 8'hc0);
    chk("ovf irq", irq, 1);
    chk("rollover pulse", rolls, exp_wraps(5, 11));
    @(negedge ref_clk) en.overflow_irq_enable = 0;
    repeat (2) @(negedge ref_clk);
    chk("ovf irq off", irq, 0);
    wr(8'hd8, 8'h40);
    rd(8'hd8, v);
    chk("ovf clear", v, 8'h40);
    wr(8'hd8, 8'hc0);
    rd(8'hd8, v);
    chk("ovf sw set", v, 8'hc0);
    wr(8'hd8, 8'h00);
    rd(8'hd8, v);
    chk("bit5", v, 8'h00);
    rd(8'hd9, v);
    chk("unmapped", v, 8'h00);
    wr(8'hd8, 8'h40);
    ticks(15);
    @(negedge ref_clk) {tick, req.wr, req.addr, req.wdata, ev} = {1'b1, 1'b1, 8'hd8, 8'h40, 5'h1f};
    @(negedge ref_clk) {tick, req.wr, ev} = 7'h00;
    rd(8'hd8, v);
    chk("set wins", v, 8'hdf);
    chk("count wrap 2", cval, exp_count(0, 16));
    chk("wrap pulses", rolls, exp_wraps(5, 11) + exp_wraps(0, 16));
    chk("irq masked", irq, exp_irq(8'hdf, en));
    wr(8'hd8, 8'h00);
    $display("test overflow done");
    ex = 8'h00;
    for (int i = 0; i < 24; i++)
    begin
      @(negedge ref_clk) evs = 5'($urandom);
      ev = evs;
      en.module_irq_enable = 5'($urandom);
      @(negedge ref_clk) ev = 0;
      ex[4:0] = ex[4:0] | evs;
      rd(8'hd8, v);
      chk("module flags", v, ex);
      chk("module irq", irq, exp_irq(ex, en));
      if (i % 4 == 3)
      begin
        ex = ex & 8'($urandom);
        wr(8'hd8, ex);
      end
    end
    $display("test module flags done");
    en.overflow_irq_enable = 1;
    wr(8'hd8, 8'hdf);
    ticks(3);
    chk("pre reset irq", irq, exp_irq(8'hdf, en));
    chk("pre reset count", cval, exp_count(0, 3));
    @(negedge ref_clk) rst = 1;
    repeat (2) @(negedge ref_clk);
    rst = 0;
    rd(8'hd8, v);
    chk("mid reset reg", v, 8'h00);
    chk("mid reset count", cval, 0);
    chk("mid reset irq", irq, 0);
    $display("test mid-run reset done");
    conclude();
  end
endmodule // test_pcs_ctrl_status

// ===== inc/pcs_defs.svh
/*
  constants for the counter array control/status register block.
  assumes a byte-wide special-function-register bus on the system clock.
*/
// How it works
// - set overflow flag, bit 7, when the shared counter rolls over from maximum
// - overflow flag requests an interrupt only while the overflow enable is set
// - overflow flag set by hardware or software write of 1; cleared only by software
// - counter advances on its count source only while run bit 6 is 1
// - only software clears the run bit; the count holds while stopped
// - module flag n, bit n for n 0..4, set on match or capture
// - module flags stay set until software writes 0; hardware never clears them
// - bit 5 is unimplemented; writes ignored, reads return 0
// - watchdog match of module 4 sets flag bit 4
// - module flag n requests interrupt only while its module enable bit is set
// - overflow and five module interrupts combine onto one request line
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
`define PCS_CTRL_ADDR 8'hd8
`define PCS_OVF_BIT 7
`define PCS_RUN_BIT 6
`define PCS_RSV_BIT 5
`define PCS_NMOD 5
`define PCS_CTRL_RESET 8'h00
`define PCS_CNT_RESET 16'h0000
`define PCS_CNT_MAX 16'hffff
`define PCS_CNT_ONE 16'h0001
`define PCS_WDOG_MOD 4
`define PCS_FLAG_RESET 1'b0
`define PCS_IDLE_RDATA 8'h00
`define PCS_RSV_VALUE 1'b0
`endif

// ===== inc/pcs_pkg.sv
/*
  types for the counter array control/status block.
  assumes pcs_defs.svh sits on the include path.
*/
`include "pcs_defs.svh"
package pcs_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcs_sfr_req_t;
  typedef struct packed {
    logic overflow_irq_enable;
    logic [`PCS_NMOD-1:0] module_irq_enable;
  } pcs_irq_en_t;
endpackage

// ===== rtl/pcs_ctrl_status.sv
/*
  control/status register of the counter array: run bit, overflow flag,
  module event flags and the shared interrupt request.
  assumes module events and count ticks are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_ctrl_status #(
  parameter int NMOD = `PCS_NMOD,
  parameter int CNT_WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input pcs_pkg::pcs_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input pcs_pkg::pcs_irq_en_t irq_en,
  input wire logic count_tick,
  input wire logic [NMOD-1:0] module_event,
  output logic [CNT_WIDTH-1:0] counter_value,
  output logic counter_rollover,
  output logic array_irq
);
  import pcs_pkg::*;

  logic counter_overflow_flag_q;
  logic counter_overflow_flag_d;
  logic counter_run_bit_q;
  logic counter_run_bit_d;
  logic [NMOD-1:0] module_event_flag_q;
  logic [NMOD-1:0] module_event_flag_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic rollover_q;
  logic [CNT_WIDTH-1:0] count_out_q;
  logic [CNT_WIDTH-1:0] count_w;
  logic rollover_w;
  logic sel;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] reg_view;

  pcs_time_base #(
    .WIDTH(CNT_WIDTH)
  ) u_time_base (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(counter_run_bit_q),
    .tick(count_tick),
    .count(count_w),
    .rollover(rollover_w)
  );

  // register decode
  assign sel = (sfr_req.addr == `PCS_CTRL_ADDR);
  assign wr_hit = sel & sfr_req.wr;
  assign rd_hit = sel & sfr_req.rd;

  // hardware set wins over a software clear in the same cycle
  assign counter_overflow_flag_d = rollover_w
    | (wr_hit ? sfr_req.wdata[`PCS_OVF_BIT] : counter_overflow_flag_q);
  // only software changes the run bit
  assign counter_run_bit_d = wr_hit ? sfr_req.wdata[`PCS_RUN_BIT]
    : counter_run_bit_q;

  genvar gi;
  generate
    for (gi = 0; gi < NMOD; gi++)
    begin : g_flag
      // module 4 also carries the watchdog match event here
      assign module_event_flag_d[gi] = module_event[gi]
        | (wr_hit ? sfr_req.wdata[gi] : module_event_flag_q[gi]);
    end
  endgenerate

  // bit 5 reads as zero and ignores writes
  assign reg_view = {counter_overflow_flag_q, counter_run_bit_q, `PCS_RSV_VALUE,
    module_event_flag_q};
  assign rdata_d = rd_hit ? reg_view : `PCS_IDLE_RDATA;

  // one shared request line for all sources
  assign irq_d = (counter_overflow_flag_d & irq_en.overflow_irq_enable)
    | (|(module_event_flag_d & irq_en.module_irq_enable));

  // sticky flags: a hardware event wins over a software clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      counter_overflow_flag_q <= `PCS_FLAG_RESET;
      module_event_flag_q <= '0;
    end
    else
    begin
      counter_overflow_flag_q <= counter_overflow_flag_d;
      module_event_flag_q <= module_event_flag_d;
    end
  end

  // run bit: changed by software writes only
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      counter_run_bit_q <= `PCS_FLAG_RESET;
    end
    else
    begin
      counter_run_bit_q <= counter_run_bit_d;
    end
  end

  // registered read data
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= `PCS_CTRL_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // registered shared request
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_q <= `PCS_FLAG_RESET;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  // registered copies of the time base
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rollover_q <= `PCS_FLAG_RESET;
      count_out_q <= CNT_WIDTH'(`PCS_CNT_RESET);
    end
    else
    begin
      rollover_q <= rollover_w;
      count_out_q <= count_w;
    end
  end

  assign sfr_rdata = rdata_q;
  assign array_irq = irq_q;
  assign counter_rollover = rollover_q;
  assign counter_value = count_out_q;

  a_ovf_set: assert property (@(posedge ref_clk) disable iff (rst)
    rollover_w |=> counter_overflow_flag_q)
    else $error("overflow flag not set on rollover");
  a_ovf_keep: assert property (@(posedge ref_clk) disable iff (rst)
    counter_overflow_flag_q && !wr_hit |=> counter_overflow_flag_q)
    else $error("overflow flag cleared without a write");
  a_ovf_clear: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && !sfr_req.wdata[`PCS_OVF_BIT] && !rollover_w |=> !counter_overflow_flag_q)
    else $error("overflow flag not cleared by a write");
  a_ovf_swset: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit && sfr_req.wdata[`PCS_OVF_BIT] |=> counter_overflow_flag_q)
    else $error("overflow flag not set by a write");
  a_run_keep: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_hit |=> $stable(counter_run_bit_q))
    else $error("run bit changed without a write");
  a_run_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_hit |=> counter_run_bit_q == $past(sfr_req.wdata[`PCS_RUN_BIT]))
    else $error("run bit does not follow the write");
  a_run_gate: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(count_w) |-> $past(counter_run_bit_q && count_tick))
    else $error("counter advanced while not running");
  a_roll_out: assert property (@(posedge ref_clk) disable iff (rst)
    rollover_w |=> counter_rollover)
    else $error("rollover pulse missing");
  a_roll_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    counter_rollover |=> counter_value == CNT_WIDTH'(`PCS_CNT_RESET))
    else $error("counter not zero after rollover");
  a_mod_set: assert property (@(posedge ref_clk) disable iff (rst)
    module_event[`PCS_WDOG_MOD] |=> module_event_flag_q[`PCS_WDOG_MOD])
    else $error("module 4 flag not set on event");
  a_mod_keep: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_hit |=> (module_event_flag_q & $past(module_event_flag_q))
      == $past(module_event_flag_q))
    else $error("module flag cleared without a write");
  a_irq_ovf: assert property (@(posedge ref_clk) disable iff (rst)
    counter_overflow_flag_q && irq_en.overflow_irq_enable ##0 $stable(irq_en)
      |-> array_irq)
    else $error("overflow request missing");
  a_irq_none: assert property (@(posedge ref_clk) disable iff (rst)
    $past(irq_en) == '0 |-> !array_irq)
    else $error("request raised with all enables off");
  a_irq_low: assert property (@(posedge ref_clk) disable iff (rst)
    !counter_overflow_flag_d && !(|module_event_flag_d) |=> !array_irq)
    else $error("request raised with no flag pending");
  a_rsv_zero: assert property (@(posedge ref_clk) disable iff (rst)
    sfr_rdata[`PCS_RSV_BIT] == `PCS_RSV_VALUE)
    else $error("reserved bit read as one");
  a_rd_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !rd_hit |=> sfr_rdata == `PCS_IDLE_RDATA)
    else $error("read data not idle without a read");
  a_rd_run: assert property (@(posedge ref_clk) disable iff (rst)
    rd_hit |=> sfr_rdata[`PCS_RUN_BIT] == $past(counter_run_bit_q))
    else $error("run bit read back wrong");

  genvar gj;
  generate
    for (gj = 0; gj < NMOD; gj++)
    begin : g_flag_check
      a_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
        module_event[gj] |=> module_event_flag_q[gj])
        else $error("module flag not set on event");
      a_flag_clear: assert property (@(posedge ref_clk) disable iff (rst)
        wr_hit && !sfr_req.wdata[gj] && !module_event[gj] |=> !module_event_flag_q[gj])
        else $error("module flag not cleared by a write");
      a_irq_module: assert property (@(posedge ref_clk) disable iff (rst)
        module_event_flag_q[gj] && irq_en.module_irq_enable[gj] ##0 $stable(irq_en)
          |-> array_irq)
        else $error("module request missing");
    end
  endgenerate
endmodule // pcs_ctrl_status

// ===== rtl/pcs_time_base.sv
/*
  shared 16-bit time base of the counter array.
  assumes the count source tick is synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_time_base #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  output logic [WIDTH-1:0] count,
  output logic rollover
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic advance;
  // advance only while running, hold otherwise
  assign advance = run & tick;
  assign count_d = advance ? count_q + WIDTH'(`PCS_CNT_ONE) : count_q;
  assign rollover = advance & (count_q == WIDTH'(`PCS_CNT_MAX));
  assign count = count_q;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= WIDTH'(`PCS_CNT_RESET);
    end
    else
    begin
      count_q <= count_d;
    end
  end
  a_hold_stop: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(run) |-> count_q == $past(count_q))
    else $error("counter moved while stopped");
endmodule // pcs_time_base
